// ===== hdl/flash_ctl.sv
// host-side controller for a parallel NOR flash: commands, polling, suspend, security
// assumes software on APB writes ADDR/WDATA, then CMD; polls STATUS busy bit
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_ctl
#(
    parameter int STROBE = `STROBE_CYC,
    parameter int ERASE_SUSP_WAIT = `ERASE_SUSP_CYC,
    parameter int PROG_SUSP_WAIT = `PROG_SUSP_CYC,
    parameter int PLANE_MSB = 21,
    parameter int PLANE_LSB = 20
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flash_ctl_pkg::flash_pins_t flash_pins,
    input wire logic [15:0] flash_din
);
    import flash_ctl_pkg::*;
    initial if (PLANE_MSB < PLANE_LSB || PLANE_MSB > 21 || ERASE_SUSP_WAIT < 1
        || PROG_SUSP_WAIT < 1) $error("flash_ctl: bad parameter");

    typedef enum {S_IDLE, S_SEQ, S_POLL, S_WAIT, S_EXIT, S_DONE} st_t;
    st_t st, next_st;
    logic [15:0] din_meta, din_sync;
    bus_cycle_t cyc, next_cyc;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic [3:0] op, next_op;
    logic [21:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [2:0] step, next_step;
    logic [2:0] nsteps, next_nsteps;
    logic [1:0] mode, next_mode;
    logic busy, next_busy;
    logic [15:0] rd, next_rd;
    logic [15:0] last_read, next_last_read;
    outcome_t outcome, next_outcome;
    logic susp_erase, next_susp_erase;
    logic susp_prog, next_susp_prog;
    logic [21:0] susp_addr, next_susp_addr;
    logic refused, next_refused;
    logic [31:0] wait_cnt, next_wait_cnt;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    // an issued cycle stays pending until the sequencer reports it done
    logic cyc_pend, next_cyc_pend;
    logic seq_own, next_seq_own;
    logic fail_seen, next_fail_seen;
    logic [3:0] run_op, next_run_op;

    // address and data of cycle n of a command sequence
    function automatic bus_cycle_t seq_cycle(input logic [3:0] o, input logic [2:0] n,
        input logic [21:0] a, input logic [15:0] d, input logic [1:0] m);
        bus_cycle_t c;
        c.req = 1'b1;
        c.wr = 1'b1;
        // the erase sequence repeats the unlock pair after its set-up cycle
        c.addr = (n[0] == (n > 3'd2)) ? `UNLOCK_A1 : `UNLOCK_A2;
        c.data = (n[0] == (n > 3'd2)) ? `UNLOCK_D1 : `UNLOCK_D2;
        case (o)
            `OP_SUSPEND: begin c.addr = a; c.data = `CMD_SUSPEND; end
            `OP_RESUME: begin c.addr = a; c.data = `CMD_RESUME; end
            `OP_PROGRAM, `OP_PROT_PROG:
                if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = (o == `OP_PROGRAM)
                    ? `CMD_PROGRAM : `CMD_PROT_PROG; end
                else if (n == 3'd3) begin c.addr = a; c.data = d; end
            `OP_PROT_LOCK:
                if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = `CMD_PROT_LOCK; end
                else if (n == 3'd3) begin c.addr = a; c.data = d & 16'hFFFD; end
            `OP_SET_MODE:
                if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = `CMD_SETCFG; end
                else if (n == 3'd3) begin c.addr = 22'h0; c.data = {14'h0, m}; end
            `OP_SECTOR_ERASE, `OP_CHIP_ERASE:
                if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = `CMD_ERASE1; end
                else if (n == 3'd5) begin
                    c.addr = (o == `OP_CHIP_ERASE) ? `UNLOCK_A1 : a;
                    c.data = (o == `OP_CHIP_ERASE) ? `CMD_CHIP : `CMD_SECTOR;
                end
            `OP_ID_ENTRY: if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = `CMD_ID_ENTRY; end
            `OP_ID_EXIT: if (n == 3'd2) begin c.addr = `UNLOCK_A1; c.data = `CMD_ID_EXIT; end
            `OP_READ: begin c.wr = 1'b0; c.addr = a; end
            default: c.req = 1'b0;
        endcase
        return c;
    endfunction : seq_cycle

    function automatic logic [2:0] seq_len(input logic [3:0] o);
        case (o)
            `OP_READ, `OP_SUSPEND, `OP_RESUME: return 3'd1;
            `OP_ID_ENTRY, `OP_ID_EXIT: return 3'd3;
            `OP_SECTOR_ERASE, `OP_CHIP_ERASE: return 3'd6;
            default: return 3'd4;
        endcase
    endfunction : seq_len

    function automatic logic is_busy_op(input logic [3:0] o);
        return o == `OP_PROGRAM || o == `OP_SECTOR_ERASE || o == `OP_CHIP_ERASE
            || o == `OP_PROT_PROG;
    endfunction : is_busy_op

    flash_cycle #(.STROBE(STROBE)) u_cycle
    (
        .core_clk(core_clk),
        .srst(srst),
        .cyc(cyc),
        .din_sync(din_sync),
        .pins(flash_pins),
        .done(cyc_done),
        .rdata(cyc_rdata)
    );

    // data pins come from the flash's own timing domain
    always_ff @(posedge core_clk)
    begin
        din_meta <= flash_din;
        din_sync <= din_meta;
    end

    logic apb_wr, apb_rd;
    assign apb_wr = psel && penable && pwrite && !pready;
    assign apb_rd = psel && penable && !pwrite && !pready;

    always_comb
    begin
        next_st = st;
        next_cyc = cyc;
        next_cyc.req = 1'b0;
        next_op = op;
        next_addr = addr;
        next_wdata = wdata;
        next_step = step;
        next_nsteps = nsteps;
        next_mode = mode;
        next_busy = busy;
        next_rd = rd;
        next_last_read = last_read;
        next_outcome = outcome;
        next_susp_erase = susp_erase;
        next_susp_prog = susp_prog;
        next_susp_addr = susp_addr;
        next_refused = refused;
        next_wait_cnt = wait_cnt;
        next_pready = apb_wr || apb_rd;
        next_pslverr = 1'b0;
        next_prdata = 32'h0;
        if (apb_rd)
            case (paddr)
                `REG_ADDR: next_prdata = {10'h0, addr};
                `REG_WDATA: next_prdata = {16'h0, wdata};
                `REG_STATUS: next_prdata = {24'h0, susp_prog, susp_erase, refused,
                    outcome, mode, busy};
                `REG_RDATA: next_prdata = {16'h0, rd};
                `REG_MODE: next_prdata = {30'h0, mode};
                `REG_CMD: next_prdata = {28'h0, op};
                default: next_pslverr = 1'b1;
            endcase
        if (apb_wr)
            case (paddr)
                `REG_ADDR: next_addr = pwdata[21:0];
                `REG_WDATA: next_wdata = pwdata[15:0];
                `REG_MODE: next_mode = (pwdata[1:0] == 2'h1) ? 2'h1 : 2'h0;
                `REG_CMD:
                    if ((busy && pwdata[3:0] != `OP_SUSPEND)
                        || (pwdata[3:0] == `OP_SUSPEND && st != S_POLL))
                        next_refused = 1'b1;
                    else if (susp_erase && (pwdata[3:0] == `OP_SECTOR_ERASE
                        || pwdata[3:0] == `OP_CHIP_ERASE))
                        next_refused = 1'b1;
                    else
                    begin
                        next_refused = 1'b0;
                        next_op = pwdata[3:0];
                        next_step = 3'd0;
                        next_nsteps = seq_len(pwdata[3:0]);
                        next_busy = 1'b1;
                        next_outcome = OUT_OK;
                        next_st = S_SEQ;
                        if (pwdata[3:0] == `OP_RESUME)
                            next_addr = susp_erase ? susp_addr : addr;
                    end
                `REG_WDATA, `REG_STATUS, `REG_RDATA: ;
                default: next_pslverr = 1'b1;
            endcase
        case (st)
            S_IDLE: ;
            S_SEQ:
                if (cyc_done && seq_own)
                begin
                    if (step + 3'd1 == nsteps)
                    begin
                        if (op == `OP_READ)
                        begin
                            next_rd = cyc_rdata;
                            next_st = S_DONE;
                        end
                        else if (op == `OP_SUSPEND)
                        begin
                            // written at ADDR; the halt time is waited out, not polled
                            next_wait_cnt = susp_prog_pending() ? PROG_SUSP_WAIT
                                : ERASE_SUSP_WAIT;
                            next_st = S_WAIT;
                        end
                        else if (op == `OP_RESUME)
                        begin
                            next_susp_erase = 1'b0;
                            next_susp_prog = 1'b0;
                            next_op = last_op_kind();
                            next_last_read = 16'h0;
                            next_st = S_POLL;
                        end
                        else if (is_busy_op(op))
                        begin
                            next_susp_addr = addr;
                            next_st = S_POLL;
                            next_last_read = 16'h0;
                            next_wait_cnt = 32'h0;
                        end
                        else
                            next_st = S_DONE;
                    end
                    else
                    begin
                        next_step = step + 3'd1;
                    end
                end
                else if (!cyc.req && !cyc_pend)
                    next_cyc = seq_cycle(op, step, addr, wdata, mode);
            S_POLL:
                if (cyc_done)
                begin
                    // status only answers at an address inside the busy plane
                    next_last_read = cyc_rdata;
                    next_wait_cnt = wait_cnt + 32'h1;
                    // in mode 01 a finished poll is still judged by the fail bits
                    if (poll_finished(cyc_rdata, last_read) && (mode != 2'h1
                        || !(cyc_rdata[`BIT_FAIL] || cyc_rdata[`BIT_VPP])))
                        next_st = (mode == 2'h1) ? S_EXIT : S_DONE;
                    else if (cyc_rdata[`BIT_FAIL] || cyc_rdata[`BIT_VPP])
                    begin
                        // recheck after a failure flag before trusting it
                        if (fail_seen)
                        begin
                            next_outcome = cyc_rdata[`BIT_VPP] ? OUT_VPP : OUT_FAIL;
                            next_st = S_EXIT;
                        end
                    end
                    else if (wait_cnt == `POLL_LIMIT)
                    begin
                        next_outcome = OUT_TIMEOUT;
                        next_st = S_EXIT;
                    end
                end
                else if (!cyc.req && !cyc_pend)
                    next_cyc = '{req: 1'b1, wr: 1'b0, addr: susp_addr, data: 16'h0};
            S_WAIT:
            begin
                next_wait_cnt = wait_cnt - 32'h1;
                if (wait_cnt <= 32'h1)
                begin
                    next_susp_erase = !susp_prog_pending();
                    next_susp_prog = susp_prog_pending();
                    next_st = S_DONE;
                end
            end
            S_EXIT:
            begin
                next_op = `OP_ID_EXIT;
                next_step = 3'd0;
                next_nsteps = 3'd3;
                next_st = S_SEQ;
            end
            S_DONE:
            begin
                next_busy = 1'b0;
                next_st = S_IDLE;
            end
            default: next_st = S_IDLE;
        endcase
    end

    // a done is taken by the command sequencer only for a cycle it issued itself
    always_comb
    begin
        next_cyc_pend = cyc_pend;
        next_seq_own = seq_own;
        if (cyc.req)
            next_cyc_pend = 1'b1;
        else if (cyc_done)
            next_cyc_pend = 1'b0;
        if (next_cyc.req)
            next_seq_own = (st == S_SEQ);
        else if (cyc_done)
            next_seq_own = 1'b0;
        next_fail_seen = fail_seen;
        if (st != S_POLL)
            next_fail_seen = 1'b0;
        else if (cyc_done)
            next_fail_seen = cyc_rdata[`BIT_FAIL] || cyc_rdata[`BIT_VPP];
        next_run_op = run_op;
        if (st == S_SEQ && is_busy_op(op))
            next_run_op = op;
    end

    function automatic logic susp_prog_pending();
        return run_op == `OP_PROGRAM || run_op == `OP_PROT_PROG;
    endfunction : susp_prog_pending

    function automatic logic [3:0] last_op_kind();
        return run_op;
    endfunction : last_op_kind

    // done when the toggle bit stops and the poll bit shows final data, or is set in mode 01
    function automatic logic poll_finished(input logic [15:0] now, input logic [15:0] prev);
        logic stable;
        logic poll_ok;
        stable = (now[`BIT_TOGGLE] == prev[`BIT_TOGGLE]) && (st == S_POLL) && (wait_cnt != 0);
        if (mode == 2'h1)
            poll_ok = now[`BIT_POLL];
        else if (run_op == `OP_PROGRAM || run_op == `OP_PROT_PROG)
            poll_ok = now[`BIT_POLL] == wdata[`BIT_POLL];
        else
            poll_ok = now[`BIT_POLL];
        return stable && poll_ok;
    endfunction : poll_finished

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st <= S_IDLE;
            cyc <= '{req: 1'b0, wr: 1'b0, addr: 22'h0, data: 16'h0};
            op <= `OP_READ;
            addr <= 22'h0;
            wdata <= 16'h0;
            step <= 3'd0;
            nsteps <= 3'd1;
            mode <= `MODE_RESET;
            busy <= 1'b0;
            rd <= 16'h0;
            last_read <= 16'h0;
            outcome <= OUT_OK;
            susp_erase <= 1'b0;
            susp_prog <= 1'b0;
            susp_addr <= 22'h0;
            refused <= 1'b0;
            wait_cnt <= 32'h0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cyc_pend <= 1'b0;
            seq_own <= 1'b0;
            fail_seen <= 1'b0;
            run_op <= `OP_READ;
        end
        else
        begin
            st <= next_st;
            cyc <= next_cyc;
            op <= next_op;
            addr <= next_addr;
            wdata <= next_wdata;
            step <= next_step;
            nsteps <= next_nsteps;
            mode <= next_mode;
            busy <= next_busy;
            rd <= next_rd;
            last_read <= next_last_read;
            outcome <= next_outcome;
            susp_erase <= next_susp_erase;
            susp_prog <= next_susp_prog;
            susp_addr <= next_susp_addr;
            refused <= next_refused;
            wait_cnt <= next_wait_cnt;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            cyc_pend <= next_cyc_pend;
            seq_own <= next_seq_own;
            fail_seen <= next_fail_seen;
            run_op <= next_run_op;
        end
    end
endmodule : flash_ctl
`default_nettype wire

// ===== hdl/flash_ctl_regs.svh
// register map, status bit positions and timing counts of the flash controller
// assumes a 100 MHz core clock and a 32-bit APB slave
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH
`define REG_CMD 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_STATUS 12'h00C
`define REG_RDATA 12'h010
`define REG_MODE 12'h014
`define BIT_POLL 7
`define BIT_TOGGLE 6
`define BIT_FAIL 5
`define BIT_VPP 3
`define BIT_ESTOG 2
`define BIT_LOCK 1
`define MODE_RESET 2'h0
`define ERASE_SUSP_NS 15000
`define PROG_SUSP_NS 10000
`define CLK_NS 10
`define ERASE_SUSP_CYC ((`ERASE_SUSP_NS) / (`CLK_NS))
`define PROG_SUSP_CYC ((`PROG_SUSP_NS) / (`CLK_NS))
`define STROBE_CYC 4
`define POLL_LIMIT 32'h0FFF_FFFF
`define UNLOCK_A1 22'h000555
`define UNLOCK_A2 22'h0002AA
`define UNLOCK_D1 16'h00AA
`define UNLOCK_D2 16'h0055
`define CMD_ID_ENTRY 16'h0090
`define CMD_ID_EXIT 16'h00F0
`define CMD_PROGRAM 16'h00A0
`define CMD_ERASE1 16'h0080
`define CMD_SECTOR 16'h0030
`define CMD_CHIP 16'h0010
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h00D0
`define CMD_SETCFG 16'h00E0
`define CMD_PROT_PROG 16'h00C0
`define CMD_PROT_LOCK 16'h00C0
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_SECTOR_ERASE 4'h2
`define OP_CHIP_ERASE 4'h3
`define OP_SUSPEND 4'h4
`define OP_RESUME 4'h5
`define OP_SET_MODE 4'h6
`define OP_ID_ENTRY 4'h7
`define OP_ID_EXIT 4'h8
`define OP_PROT_PROG 4'h9
`define OP_PROT_LOCK 4'hA
`endif

// ===== hdl/flash_ctl_pkg.sv
// types shared by the flash controller and its pin sequencer
// assumes the constants header is included by its users
package flash_ctl_pkg;
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dout;
        logic dout_en_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } flash_pins_t;
    typedef struct packed {
        logic req;
        logic wr;
        logic [21:0] addr;
        logic [15:0] data;
    } bus_cycle_t;
    typedef enum logic [1:0] {OUT_OK, OUT_FAIL, OUT_VPP, OUT_TIMEOUT} outcome_t;
endpackage : flash_ctl_pkg

// ===== hdl/flash_cycle.sv
// one asynchronous flash bus cycle: a write strobe or a read with data capture
// assumes the flash data pins are synchronised by the caller's two-stage chain
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_cycle
#(
    parameter int STROBE = `STROBE_CYC
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire flash_ctl_pkg::bus_cycle_t cyc,
    input wire logic [15:0] din_sync,
    output flash_ctl_pkg::flash_pins_t pins,
    output logic done,
    output logic [15:0] rdata
);
    import flash_ctl_pkg::*;
    initial if (STROBE < 3 || STROBE > 255) $error("flash_cycle: STROBE out of range");
    typedef enum {C_IDLE, C_STROBE, C_HOLD} cst_t;
    cst_t st, next_st;
    logic [7:0] cnt, next_cnt;
    flash_pins_t next_pins;
    logic next_done;
    logic [15:0] next_rdata;
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_pins = pins;
        next_done = 1'b0;
        next_rdata = rdata;
        case (st)
            C_IDLE:
            begin
                if (cyc.req)
                begin
                    next_pins.addr = cyc.addr;
                    next_pins.dout = cyc.data;
                    next_pins.dout_en_n = ~cyc.wr;
                    next_pins.ce_n = 1'b0;
                    next_pins.oe_n = cyc.wr;
                    next_pins.we_n = ~cyc.wr;
                    next_cnt = 8'(STROBE);
                    next_st = C_STROBE;
                end
            end
            C_STROBE:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h01)
                begin
                    // data from the sync chain lags the strobe by two cycles
                    next_rdata = din_sync;
                    next_pins.we_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_pins.ce_n = 1'b1;
                    next_st = C_HOLD;
                end
            end
            C_HOLD:
            begin
                next_pins.dout_en_n = 1'b1;
                next_done = 1'b1;
                next_st = C_IDLE;
            end
            default: next_st = C_IDLE;
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st <= C_IDLE;
            cnt <= 8'h00;
            pins <= '{addr: 22'h0, dout: 16'h0, dout_en_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
                      we_n: 1'b1, reset_n: 1'b1};
            done <= 1'b0;
            rdata <= 16'h0000;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            pins <= next_pins;
            done <= next_done;
            rdata <= next_rdata;
        end
    end
endmodule : flash_cycle
`default_nettype wire

// ===== verification/flash_ctl_monitor.sv
// port checks for the flash controller
// bound into every flash_ctl
`timescale 1ns/10ps
`default_nettype none
module flash_ctl_monitor
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire flash_ctl_pkg::flash_pins_t flash_pins
);
    import flash_ctl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("access not answered");
    property p_pls; pready |=> !pready; endproperty
    a_pls: assert property (p_pls) else $error("ready too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rst; $fell(srst) |-> flash_pins.we_n && flash_pins.oe_n; endproperty
    a_rst: assert property (p_rst) else $error("strobe low after reset");
    property p_pin; flash_pins.reset_n; endproperty
    a_pin: assert property (p_pin) else $error("device reset pulsed");
    property p_wr; $fell(flash_pins.we_n) |-> !flash_pins.we_n[*4] ##1 flash_pins.we_n; endproperty
    a_wr: assert property (p_wr) else $error("write strobe length");
    property p_drv; !flash_pins.we_n |-> !flash_pins.dout_en_n && flash_pins.oe_n; endproperty
    a_drv: assert property (p_drv) else $error("write without data");
    property p_rd; !flash_pins.oe_n |-> flash_pins.dout_en_n; endproperty
    a_rd: assert property (p_rd) else $error("read while driving");
endmodule : flash_ctl_monitor
bind flash_ctl flash_ctl_monitor flash_ctl_monitor_i (.core_clk(core_clk), .srst(srst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .flash_pins(flash_pins));
`default_nettype wire

// ===== verification/flash_model.sv
// behavioural flash device on the controller pins
// assumes cycles qualified by chip enable low
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_regs.svh"
module flash_model
(
    input wire flash_ctl_pkg::flash_pins_t pins,
    input wire logic fail,
    output logic [15:0] flash_din
);
    import flash_ctl_pkg::*;
    logic [15:0] mem [int];
    logic [15:0] last = 16'h0000, q = 16'h0000, w;
    logic [1:0] mode = 2'h0;
    logic tog = 0, er = 0, st = 0, fl = 0, susp = 0, lockd1 = 1, wsel = 0;
    int busy = 0, nxt = 0;
    assign w = pins.dout;
    // reset pin ignored so the stored mode survives it
    // chip enable rises with the write strobe, so it is taken at the falling edge
    always @(negedge pins.we_n)
        wsel = !pins.ce_n;
    always @(posedge pins.we_n)
        if (wsel)
        begin
            if (nxt == 1)
                {mem[pins.addr], last, busy, er, st, fl} = {w, w, 32'd3, 2'h1, fail};
            else if (nxt == 2)
                mode = w[1:0];
            else if (nxt == 3)
                lockd1 = w[1];
            else if (!susp && (w == `CMD_SECTOR || w == `CMD_CHIP))
                {busy, er, st, fl} = {32'd40, 2'h3, fail};
            else if (w == `CMD_SUSPEND || w == `CMD_RESUME)
                susp = w == `CMD_SUSPEND;
            else if (w == `CMD_ID_EXIT)
                {st, fl} = 2'h0;
            nxt = nxt != 0 ? 0 : w == `CMD_PROGRAM ? 1 : w == `CMD_SETCFG ? 2 :
                w == `CMD_PROT_LOCK ? 3 : 0;
        end
    always @(negedge pins.oe_n)
        if (!pins.ce_n)
        begin
            if (st && busy > 0 && !susp)
                {busy, tog} = {busy - 1, !tog};
            if (busy == 0 && !fl && mode == 2'h0)
                st = 1'h0;
            q = !st ? (mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF) :
                {8'h00, mode[0] ? busy == 0 : !er && !last[7], tog, fl && busy == 0, 5'h00};
        end
    // a released bus shows the inverse of the last word
    assign flash_din = !pins.oe_n && !pins.ce_n ? q : ~q;
endmodule : flash_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the flash controller
// assumes the device model answers its pins
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_regs.svh"
module tb_top;
    import flash_ctl_pkg::*;
    logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fail = 0, err, m;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr;
    logic [15:0] flash_din, d;
    logic [21:0] a;
    flash_pins_t flash_pins;
    int n_errors = 0, tests_run = 0, seed = 60813, k;
    always #5 core_clk = ~core_clk;
    flash_ctl #(.ERASE_SUSP_WAIT(10), .PROG_SUSP_WAIT(10)) flash_ctl_i (.core_clk(core_clk),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_pins(flash_pins), .flash_din(flash_din));
    flash_model flash_model_i (.pins(flash_pins), .fail(fail), .flash_din(flash_din));
    task automatic test_done;
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [31:0] st_exp(input logic md, input logic bad);
        return {28'h0, bad, 1'h0, md, 1'h0};
    endfunction : st_exp
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int i;
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, ad, wd};
        @(posedge core_clk);
        penable <= 1'h1;
        for (i = 0; i < 9 && pready !== 1'h1; i++)
            @(posedge core_clk);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        n_errors += i / 9;
        if (i == 9)
            test_done;
    endtask : apb
    task automatic wait_st(input int b, input logic v);
        int i;
        for (i = 0; i < 3000 && rd[b] !== v; i++)
            apb(1'h0, `REG_STATUS, 32'h0);
        n_errors += i / 3000;
        if (i == 3000)
            test_done;
    endtask : wait_st
    task automatic op(input logic [3:0] c, input logic [21:0] ad, input logic [15:0] wd);
        apb(1'h1, `REG_ADDR, {10'h0, ad});
        apb(1'h1, `REG_WDATA, {16'h0, wd});
        apb(1'h1, `REG_CMD, {28'h0, c});
        rd = 32'hFFFF_FFFF;
    endtask : op
    initial
    begin
        repeat (3) @(posedge core_clk);
        srst <= 1'h0;
        apb(1'h0, `REG_MODE, 32'h0);
        chk("mode_reset", rd, 32'h0);
        apb(1'h0, 12'hFF0, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        for (k = 0; k < 6; k++)
        begin
            {m, a, d} = {k[0], 22'($random(seed)), 16'($random(seed))};
            fail = k > 3;
            apb(1'h1, `REG_MODE, {31'h0, m});
            op(`OP_SET_MODE, 22'h0, {15'h0, m});
            wait_st(0, 1'h0);
            op(`OP_PROGRAM, a, d);
            wait_st(0, 1'h0);
            chk("outcome", rd & 32'h1F, st_exp(m, k > 3));
            op(`OP_READ, a, 16'h0);
            wait_st(0, 1'h0);
            apb(1'h0, `REG_RDATA, 32'h0);
            chk("rdata", rd & 32'hFFFF, {16'h0, d});
        end
        fail = 1'h0;
        op(`OP_SECTOR_ERASE, a, 16'h0);
        // suspend is refused until the erase has reached its polling
        k = 0;
        do
        begin
            op(`OP_SUSPEND, 22'h0, 16'h0);
            apb(1'h0, `REG_STATUS, 32'h0);
            k++;
        end
        while (rd[5] && k < 99);
        wait_st(6, 1'h1);
        op(`OP_SECTOR_ERASE, a ^ 22'h008000, 16'h0);
        apb(1'h0, `REG_STATUS, 32'h0);
        chk("refused", rd & 32'h20, 32'h20);
        op(`OP_RESUME, a, 16'h0);
        wait_st(0, 1'h0);
        chk("erase", rd & 32'h19, 32'h0);
        op(`OP_PROT_LOCK, 22'h0, 16'hFFFF);
        wait_st(0, 1'h0);
        chk("lock", {31'h0, flash_model_i.lockd1}, 32'h0);
        op(`OP_CHIP_ERASE, a, 16'h0);
        wait_st(0, 1'h0);
        chk("chip_erase", rd & 32'h19, 32'h0);
        test_done;
    end
endmodule : tb_top
`default_nettype wire
